//--- dv/ccs_host_model.sv
// Serial bus host controller model that drives the clock and data pins of the bank.
`timescale 1ns/1ps
module ccs_host_model (
  // Clock
  input wire logic sys_clk,
  // Serial pins
  input wire logic sda,
  output logic scl,
  output logic sda_low,
  // Results
  output logic rd_done,
  output logic [7:0] rd_data,
  output logic [7:0] nak_cnt
);
  localparam int HALF = 8;

  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
    rd_done = 1'b0;
    rd_data = 8'h00;
    nak_cnt = 8'h00;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic wt(input int n);
    repeat (n) @(posedge sys_clk);
  endtask

  // Data only moves while the clock is low, so no false start or stop is seen.
  task automatic bit_io(input logic b, output logic s);
    sda_low <= ~b;
    wt(HALF / 2);
    scl <= 1'b1;
    wt(HALF / 2);
    s = sda;
    wt(HALF / 2);
    scl <= 1'b0;
    wt(HALF / 2);
  endtask

  task automatic start_c();
    sda_low <= 1'b0;
    wt(HALF / 2);
    scl <= 1'b1;
    wt(HALF / 2);
    sda_low <= 1'b1;
    wt(HALF / 2);
    scl <= 1'b0;
    wt(HALF / 2);
  endtask

  task automatic stop_c();
    sda_low <= 1'b1;
    wt(HALF / 2);
    scl <= 1'b1;
    wt(HALF / 2);
    sda_low <= 1'b0;
    wt(HALF);
  endtask

  task automatic byte_wr(input logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, s);
    if (s) nak_cnt <= nak_cnt + 8'h01;
  endtask

  task automatic byte_rd(input logic last);
    logic [7:0] d;
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
    bit_io(last, s);
    rd_data <= d;
    rd_done <= 1'b1;
    wt(1);
    rd_done <= 1'b0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  task automatic write_regs(input logic [6:0] dev, input logic [7:0] ptr, input logic [7:0] d[$]);
    start_c();
    byte_wr({dev, 1'b0});
    byte_wr(ptr);
    foreach (d[i]) byte_wr(d[i]);
    stop_c();
  endtask

  task automatic read_regs(input logic [6:0] dev, input logic [7:0] ptr, input int n);
    start_c();
    byte_wr({dev, 1'b0});
    byte_wr(ptr);
    start_c();
    byte_wr({dev, 1'b1});
    for (int i = 0; i < n; i++) byte_rd(i == n - 1);
    stop_c();
  endtask
endmodule // ccs_host_model

//--- dv/tb_top.sv
// Self-checking bench for the charger current setting bank.
`timescale 1ns/1ps
`include "ccs_map.svh"
module tb_top;
  localparam logic [6:0] DEV = 7'h2a;
  // Fast-charge code the host is taken to have programmed elsewhere.
  localparam logic [5:0] FAST_CODE = 6'h3f;
  logic sys_clk;
  logic resetn;
  logic [4:0] key;
  logic scl, sda_low, rd_done, sda_o, sda_oe;
  logic [7:0] rd_data, nak_cnt, v0, v1;
  logic [5:0] topoff, prechg;
  wire sda = ~(sda_low | sda_oe);
  int num_errors, compares, cycles;
  logic [7:0] exp_q[$];

  ccs_top dut (.sys_clk(sys_clk), .resetn(resetn), .scl_i(scl), .sda_i(sda), .sda_o(sda_o),
    .sda_oe(sda_oe), .charger_write_unlock_key(key), .topoff_current_code(topoff),
    .precharge_current_code(prechg));
  ccs_host_model host (.sys_clk(sys_clk), .sda(sda), .scl(scl), .sda_low(sda_low),
    .rd_done(rd_done), .rd_data(rd_data), .nak_cnt(nak_cnt));

  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic finish_test();
    $display("errors %0d compares %0d", num_errors, compares);
    if (num_errors == 0 && compares > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  task automatic rd_pair(input logic [7:0] ptr, input logic [7:0] e0, input logic [7:0] e1);
    exp_q.push_back(e0);
    exp_q.push_back(e1);
    host.read_regs(DEV, ptr, 2);
  endtask

  task automatic codes(input logic [7:0] e0, input logic [7:0] e1);
    check("topoff code", {2'b00, topoff}, {2'b00, e0[5:0]});
    check("precharge code", {2'b00, prechg}, {2'b00, e1[5:0]});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    sys_clk = 1'b0;
    forever #4 sys_clk = ~sys_clk;
  end

  // Read bytes come back in request order, so the oldest note is the one to match.
  always @(posedge sys_clk) begin
    if (rd_done === 1'b1) check("read byte", rd_data, exp_q.pop_front());
  end

  // Seventeen transfers of at most about eight hundred cycles each fit well inside this ceiling.
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      finish_test();
    end
  end

  initial begin
    resetn = 1'b0;
    key = 5'h00;
    v0 = 8'($urandom(17833));
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    codes(8'h04, 8'h08);
    rd_pair(`CCS_TOPOFF_ADDR, 8'h04, 8'h08);
    key <= `CCS_UNLOCK_KEY ^ (5'h01 + 5'($urandom % 31));
    host.write_regs(DEV, `CCS_TOPOFF_ADDR, '{8'hff, 8'hff});
    codes(8'h04, 8'h08);
    rd_pair(`CCS_TOPOFF_ADDR, 8'h04, 8'h08);
    key <= `CCS_UNLOCK_KEY;
    for (int i = 0; i < 5; i++) begin
      v0 = (i == 0) ? 8'h00 : (i == 1) ? 8'hff : 8'($urandom);
      v1 = (i == 0) ? 8'h00 : (i == 1) ? 8'h3f : 8'($urandom);
      if (v1[5:0] > FAST_CODE) v1[5:0] = FAST_CODE;
      host.write_regs(DEV, `CCS_TOPOFF_ADDR, '{v0, v1});
      codes(v0, v1);
      rd_pair(`CCS_TOPOFF_ADDR, v0, v1);
    end
    host.write_regs(DEV, 8'h20, '{8'h5a});
    rd_pair(8'h20, `CCS_UNMAPPED_RD, `CCS_UNMAPPED_RD);
    check("ack count", nak_cnt, 8'h00);
    host.write_regs(DEV ^ 7'h01, `CCS_TOPOFF_ADDR, '{8'h11});
    check("ack count", nak_cnt, 8'h03);
    codes(v0, v1);
    // A reset in mid-run must bring back the defaults over the written values.
    resetn <= 1'b0;
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    repeat (3) @(posedge sys_clk);
    codes(8'h04, 8'h08);
    rd_pair(`CCS_TOPOFF_ADDR, 8'h04, 8'h08);
    check("data pin level", {7'h00, sda_o}, 8'h00);
    check("pending reads", 8'(exp_q.size()), 8'h00);
    finish_test();
  end
endmodule // tb_top

//--- include/ccs_map.svh
// Register offsets, reset values and the unlock key of the charger current setting bank.
`ifndef CCS_MAP_SVH
`define CCS_MAP_SVH
`define CCS_TOPOFF_ADDR 8'h12
`define CCS_PRECHG_ADDR 8'h13
`define CCS_UNLOCK_KEY 5'h15
`define CCS_RSVD_RST 2'h0
`define CCS_TOPOFF_RST 6'h04
`define CCS_PRECHG_HI_RST 1'h0
`define CCS_PRECHG_TRIM_RST 2'h1
`define CCS_PRECHG_LO_RST 3'h0
`define CCS_UNMAPPED_RD 8'h00
`define CCS_BYTE_BITS 4'h8
`define CCS_LAST_TX_BIT 4'h7
`endif

//--- include/ccs_pkg.sv
// Types shared by the charger current setting bank.
package ccs_pkg;
  typedef enum logic [8:0] {
    ST_IDLE  = 9'h001,
    ST_ADDR  = 9'h002,
    ST_AACK  = 9'h004,
    ST_RXREG = 9'h008,
    ST_RACK  = 9'h010,
    ST_RXDAT = 9'h020,
    ST_DACK  = 9'h040,
    ST_TX    = 9'h080,
    ST_MACK  = 9'h100
  } ccs_state_t;
endpackage

//--- include/ccs_reg_if.sv
// Internal register access path between the serial target and the register bank.
`timescale 1ns/1ps
interface ccs_reg_if;
  logic wr_en;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport bank (input wr_en, input addr, input wdata, output rdata);
endinterface

//--- rtl/ccs_regs.sv
// Lock-protected top-off and pre-charge current configuration registers.
`timescale 1ns/1ps
`include "ccs_map.svh"
module ccs_regs
  import ccs_pkg::*;
#(
  parameter logic [5:0] TOPOFF_RST = `CCS_TOPOFF_RST,
  parameter logic [1:0] PRECHG_TRIM = `CCS_PRECHG_TRIM_RST
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Register access
  ccs_reg_if.bank bus,
  input wire logic [4:0] unlock_key,
  // Charger codes
  output logic [5:0] topoff_current_code,
  output logic [5:0] precharge_current_code
);
  localparam logic [7:0] TOPOFF_RST_VAL = {`CCS_RSVD_RST, TOPOFF_RST};
  localparam logic [7:0] PRECHG_RST_VAL = {`CCS_RSVD_RST, `CCS_PRECHG_HI_RST, PRECHG_TRIM,
                                           `CCS_PRECHG_LO_RST};

  logic [7:0] topoff_cfg_r;
  logic [7:0] precharge_cfg_r;

  wire unlocked = (unlock_key == `CCS_UNLOCK_KEY);
  wire topoff_sel = (bus.addr == `CCS_TOPOFF_ADDR);
  wire prechg_sel = (bus.addr == `CCS_PRECHG_ADDR);
  wire topoff_we = bus.wr_en & unlocked & topoff_sel;
  wire prechg_we = bus.wr_en & unlocked & prechg_sel;

  ////////////////////////////////////////////////////////////////////////////
  // Reserved bits are stored and read back but never leave the bank.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      topoff_cfg_r <= TOPOFF_RST_VAL;
      precharge_cfg_r <= PRECHG_RST_VAL;
    end else begin
      if (topoff_we) begin
        topoff_cfg_r <= bus.wdata;
      end
      if (prechg_we) begin
        precharge_cfg_r <= bus.wdata;
      end
    end
  end

  assign topoff_current_code = topoff_cfg_r[5:0];
  assign precharge_current_code = precharge_cfg_r[5:0];
  assign bus.rdata = topoff_sel ? topoff_cfg_r :
                     prechg_sel ? precharge_cfg_r : `CCS_UNMAPPED_RD;

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_LOCKED_HOLD: assert property (
    bus.wr_en && !unlocked |=> $stable(topoff_cfg_r) && $stable(precharge_cfg_r))
    else $error("locked write changed a register");
  AST_TOPOFF_WRITE: assert property (
    topoff_we |=> topoff_cfg_r == $past(bus.wdata) && $stable(precharge_cfg_r))
    else $error("top-off write not taken");
  AST_PRECHG_WRITE: assert property (
    prechg_we |=> precharge_cfg_r == $past(bus.wdata) && $stable(topoff_cfg_r))
    else $error("pre-charge write not taken");
  AST_TOPOFF_RESET: assert property (
    !$past(resetn) |-> topoff_cfg_r == TOPOFF_RST_VAL)
    else $error("top-off reset value wrong");
  AST_PRECHG_RESET: assert property (
    !$past(resetn) |-> precharge_cfg_r == PRECHG_RST_VAL && precharge_cfg_r[7:5] == 3'h0 &&
                       precharge_cfg_r[2:0] == 3'h0)
    else $error("pre-charge reset value wrong");
  AST_CODE_OUT: assert property (
    topoff_we |=> topoff_current_code == $past(bus.wdata[5:0]))
    else $error("top-off code does not follow the register");
  AST_RSVD_RW: assert property (
    prechg_we |=> precharge_current_code == $past(bus.wdata[5:0]) &&
                  bus.rdata[7:6] == $past(bus.wdata[7:6]) || !prechg_sel)
    else $error("reserved bits not read as written");
  CVR_LOCKED_WRITE: cover property (bus.wr_en && !unlocked && (topoff_sel || prechg_sel));
endmodule // ccs_regs

//--- rtl/ccs_top.sv
// Serial target front end and top of the charger current setting bank.
`timescale 1ns/1ps
`include "ccs_map.svh"
module ccs_top
  import ccs_pkg::*;
#(
  // Target address value is arbitrary.
  parameter logic [6:0] TARGET_ADDR = 7'h2a,
  parameter logic [5:0] TOPOFF_RST = `CCS_TOPOFF_RST,
  parameter logic [1:0] PRECHG_TRIM = `CCS_PRECHG_TRIM_RST
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic resetn,
  // Serial bus pins
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe,
  // Lock key from the lock register
  input wire logic [4:0] charger_write_unlock_key,
  // Charger codes
  output logic [5:0] topoff_current_code,
  output logic [5:0] precharge_current_code
);
  ccs_state_t state_r;
  ccs_state_t state_nxt;
  logic scl_meta_r;
  logic scl_sync_r;
  logic scl_prev_r;
  logic sda_meta_r;
  logic sda_sync_r;
  logic sda_prev_r;
  logic [3:0] cnt_r;
  logic [3:0] cnt_nxt;
  logic [7:0] shift_r;
  logic [7:0] shift_nxt;
  logic [7:0] ptr_r;
  logic [7:0] ptr_nxt;
  logic rw_r;
  logic rw_nxt;
  logic nack_r;
  logic nack_nxt;
  logic sda_oe_r;
  logic oe_nxt;
  logic wr_en_r;
  logic wr_nxt;
  logic sda_o_r;

  ccs_reg_if reg_bus ();

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers; only the second stage and its delayed copy are decoded.
  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      scl_meta_r <= 1'b1;
      scl_sync_r <= 1'b1;
      scl_prev_r <= 1'b1;
      sda_meta_r <= 1'b1;
      sda_sync_r <= 1'b1;
      sda_prev_r <= 1'b1;
    end else begin
      scl_meta_r <= scl_i;
      scl_sync_r <= scl_meta_r;
      scl_prev_r <= scl_sync_r;
      sda_meta_r <= sda_i;
      sda_sync_r <= sda_meta_r;
      sda_prev_r <= sda_sync_r;
    end
  end

  wire scl_rise = scl_sync_r & ~scl_prev_r;
  wire scl_fall = ~scl_sync_r & scl_prev_r;
  wire scl_held = scl_sync_r & scl_prev_r;
  wire start_det = scl_held & sda_prev_r & ~sda_sync_r;
  wire stop_det = scl_held & ~sda_prev_r & sda_sync_r;
  wire byte_done = (cnt_r == `CCS_BYTE_BITS);
  wire addr_hit = (shift_r[7:1] == TARGET_ADDR);
  wire last_tx_bit = (cnt_r == `CCS_LAST_TX_BIT);

  ////////////////////////////////////////////////////////////////////////////
  // Bits are sampled on the rising clock and the data line is only changed
  // after a falling clock, so the host always sees stable data while high.
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    shift_nxt = shift_r;
    ptr_nxt = ptr_r;
    rw_nxt = rw_r;
    nack_nxt = nack_r;
    oe_nxt = sda_oe_r;
    wr_nxt = 1'b0;
    if (stop_det) begin
      state_nxt = ST_IDLE;
      oe_nxt = 1'b0;
    end else if (start_det) begin
      state_nxt = ST_ADDR;
      cnt_nxt = 4'h0;
      oe_nxt = 1'b0;
    end else begin
      unique case (state_r)
        ST_IDLE: begin
          oe_nxt = 1'b0;
        end
        ST_ADDR, ST_RXREG, ST_RXDAT: begin
          if (scl_rise) begin
            shift_nxt = {shift_r[6:0], sda_sync_r};
            cnt_nxt = cnt_r + 4'h1;
          end else if (scl_fall && byte_done) begin
            cnt_nxt = 4'h0;
            oe_nxt = 1'b1;
            if (state_r == ST_ADDR) begin
              if (addr_hit) begin
                state_nxt = ST_AACK;
                rw_nxt = shift_r[0];
              end else begin
                state_nxt = ST_IDLE;
                oe_nxt = 1'b0;
              end
            end else if (state_r == ST_RXREG) begin
              state_nxt = ST_RACK;
              ptr_nxt = shift_r;
            end else begin
              state_nxt = ST_DACK;
              wr_nxt = 1'b1;
            end
          end
        end
        ST_AACK, ST_RACK, ST_DACK: begin
          if (scl_fall) begin
            oe_nxt = 1'b0;
            state_nxt = ST_RXDAT;
            if (state_r == ST_AACK && rw_r) begin
              state_nxt = ST_TX;
              shift_nxt = reg_bus.rdata;
              oe_nxt = ~reg_bus.rdata[7];
            end else if (state_r == ST_AACK) begin
              state_nxt = ST_RXREG;
            end
            if (state_r == ST_DACK) begin
              ptr_nxt = ptr_r + 8'h01;
            end
          end
        end
        ST_TX: begin
          if (scl_fall) begin
            cnt_nxt = cnt_r + 4'h1;
            if (last_tx_bit) begin
              state_nxt = ST_MACK;
              oe_nxt = 1'b0;
              ptr_nxt = ptr_r + 8'h01;
            end else begin
              shift_nxt = {shift_r[6:0], 1'b0};
              oe_nxt = ~shift_r[6];
            end
          end
        end
        ST_MACK: begin
          if (scl_rise) begin
            nack_nxt = sda_sync_r;
          end else if (scl_fall) begin
            if (nack_r) begin
              state_nxt = ST_IDLE;
            end else begin
              state_nxt = ST_TX;
              cnt_nxt = 4'h0;
              shift_nxt = reg_bus.rdata;
              oe_nxt = ~reg_bus.rdata[7];
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= ST_IDLE;
      cnt_r <= 4'h0;
      shift_r <= 8'h00;
      ptr_r <= 8'h00;
      rw_r <= 1'b0;
      nack_r <= 1'b0;
      sda_oe_r <= 1'b0;
      wr_en_r <= 1'b0;
      sda_o_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      shift_r <= shift_nxt;
      ptr_r <= ptr_nxt;
      rw_r <= rw_nxt;
      nack_r <= nack_nxt;
      sda_oe_r <= oe_nxt;
      wr_en_r <= wr_nxt;
      sda_o_r <= 1'b0;
    end
  end

  assign sda_o = sda_o_r;
  assign sda_oe = sda_oe_r;
  assign reg_bus.wr_en = wr_en_r;
  assign reg_bus.addr = ptr_r;
  assign reg_bus.wdata = shift_r;

  ////////////////////////////////////////////////////////////////////////////
  // The host is trusted to keep the pre-charge code below the fast-charge
  // code; the bank stores whatever an unlocked write brings.
  ccs_regs #(
    .TOPOFF_RST(TOPOFF_RST),
    .PRECHG_TRIM(PRECHG_TRIM)
  ) u_regs (
    .sys_clk(sys_clk),
    .resetn(resetn),
    .bus(reg_bus),
    .unlock_key(charger_write_unlock_key),
    .topoff_current_code(topoff_current_code),
    .precharge_current_code(precharge_current_code)
  );

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  AST_STOP_IDLE: assert property (stop_det |=> state_r == ST_IDLE && !sda_oe_r)
    else $error("stop did not return to idle");
  AST_START_ADDR: assert property (start_det && !stop_det |=> state_r == ST_ADDR && cnt_r == 4'h0)
    else $error("start did not begin an address byte");
  AST_WR_PULSE: assert property (
    wr_en_r |-> state_r == ST_DACK && $past(state_r) == ST_RXDAT ##1 !wr_en_r)
    else $error("write strobe out of place");
  AST_ACK_DRIVE: assert property (
    $rose(state_r == ST_AACK) |-> sda_oe_r && $past(addr_hit) && $past(scl_fall))
    else $error("address acknowledge not driven");
  AST_PTR_STEP: assert property (
    state_r == ST_DACK && scl_fall && !start_det && !stop_det |=> ptr_r == $past(ptr_r) + 8'h01)
    else $error("register pointer did not advance");
  CVR_WRITE: cover property (wr_en_r);
  CVR_READ: cover property (state_r == ST_MACK && scl_fall && !nack_r);
  CVR_MISS: cover property (state_r == ST_ADDR && scl_fall && byte_done && !addr_hit);
endmodule // ccs_top
